// ===== telemetry_direct_format_energy.sv
// Telemetry encoder: voltage, current, squared current, power, temperature
// in direct format, limit decoding, and the energy accumulator.
// Assumes the analog front end presents sampled values in fixed point.
//
// What this block does
// - Every reading and limit is coded as (m*X + b)*10^R, decoded by the inverse.
// - In the 88 V range voltage uses m=4653, b=0, R=-2.
// - Current is per 1 mOhm and scaled by Rsns; 12.5 mV setting gives m=23165, R=-2.
// - Squared current is 16 bits with m=20808, b=0, R=-2, also per 1 mOhm.
// - Input power is voltage times current, per 1 mOhm and scaled by Rsns.
// - The 16-bit power reading uses m=4211, b=0, R=-2.
// - Power is also given as a 24-bit reading with m=10780, b=0, R=0.
// - Temperature and its fault limit use m=52, b=14321, R=-1.
// - The 12-bit temperature limit accepts any code 0x000 to 0xFFF.
// - The energy accumulator sums the 16-bit power codes.
// - Energy readout gives sample count, rollover count and power count.
// - One conversion each 102.4 us, adding exactly one sample to the sum.
`timescale 1ns/1ps
`include "telemetry_map.svh"
module telemetry_direct_format_energy #(
	parameter int CONV_CYCLES = `CONV_CYCLES,
	parameter int ACC_W = 16,
	parameter int ROLL_W = 8,
	parameter int SAMP_W = 16
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Configuration
	input wire logic voltage_telemetry_range,
	input wire logic [1:0] current_sense_threshold_setting,
	input wire logic [15:0] rsns_milli_x100,
	// Measured values: volts x100, amps x100, amps^2 x100, kelvin-offset degC x10
	input wire logic [15:0] vin_x100,
	input wire logic [15:0] iout_x100,
	input wire logic [23:0] isq_x100,
	input wire logic [15:0] temp_c_x10_plus2730,
	// Programmed temperature limit
	input wire logic [11:0] ot_fault_limit_code,
	// Readings
	output logic [11:0] vin_reading,
	output logic [11:0] iout_reading,
	output logic [15:0] squared_current_reading,
	output logic [15:0] pin_reading,
	output logic [23:0] extended_power_reading,
	output logic [11:0] temp_reading,
	output logic ot_fault,
	output logic [11:0] ot_limit_degc_plus273,
	output logic coeff_valid,
	// Energy readout
	output logic [SAMP_W-1:0] sample_count,
	output logic [ROLL_W-1:0] rollover_count,
	output logic [ACC_W-1:0] energy_count,
	output logic conv_done
);
	localparam int CW = $clog2(CONV_CYCLES);
	// Temperature offset re-based to degC+273 so no term goes negative
	localparam logic [15:0] TEMP_B_K = 16'(`TEMP_B - `TEMP_M * 16'h0111);
	logic [CW-1:0] tick_r;
	logic [15:0] vin_s1_r, vin_s2_r;
	logic [15:0] iout_s1_r, iout_s2_r;
	logic [15:0] temp_s1_r, temp_s2_r;
	logic [23:0] isq_s1_r, isq_s2_r;
	logic [31:0] pin_x10000;
	logic [15:0] limit_x10;
	logic [11:0] limit_nxt;
	telemetry_pkg::conv_state_t state_r;
	logic [ACC_W+ROLL_W-1:0] acc_sum;

	// Front-end values cross from the converter; two stages each
	// Words are not gray coded: one caught mid-change is off for one sample only
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vin_s1_r <= 16'h0000;
			vin_s2_r <= 16'h0000;
			iout_s1_r <= 16'h0000;
			iout_s2_r <= 16'h0000;
			isq_s1_r <= 24'h000000;
			isq_s2_r <= 24'h000000;
			temp_s1_r <= 16'h0000;
			temp_s2_r <= 16'h0000;
		end
		else
		begin
			vin_s1_r <= vin_x100;
			vin_s2_r <= vin_s1_r;
			iout_s1_r <= iout_x100;
			iout_s2_r <= iout_s1_r;
			isq_s1_r <= isq_x100;
			isq_s2_r <= isq_s1_r;
			temp_s1_r <= temp_c_x10_plus2730;
			temp_s2_r <= temp_s1_r;
		end
	end

	// Only the 88 V range and 12.5 mV setting have coefficients here
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			coeff_valid <= 1'b0;
		else
			coeff_valid <= voltage_telemetry_range && (current_sense_threshold_setting == 2'b00);
	end

	assign pin_x10000 = 32'(vin_s2_r) * 32'(iout_s2_r);

	direct_encoder #(.XW(16), .YW(`W12), .X_DIV(100), .M(`VOLT_M), .B(`VOLT_B),
		.EXP(telemetry_pkg::EXP_M2), .SCALE_RSNS(1'b0)) u_vin (
		.ref_clk(ref_clk), .arst_n(arst_n), .x_val(vin_s2_r),
		.rsns_milli_x100(rsns_milli_x100), .y_val(vin_reading));

	direct_encoder #(.XW(16), .YW(`W12), .X_DIV(100), .M(`CURR_M), .B(`CURR_B),
		.EXP(telemetry_pkg::EXP_M2), .SCALE_RSNS(1'b1)) u_iout (
		.ref_clk(ref_clk), .arst_n(arst_n), .x_val(iout_s2_r),
		.rsns_milli_x100(rsns_milli_x100), .y_val(iout_reading));

	direct_encoder #(.XW(24), .YW(`W16), .X_DIV(100), .M(`ISQ_M), .B(`ISQ_B),
		.EXP(telemetry_pkg::EXP_M2), .SCALE_RSNS(1'b1)) u_isq (
		.ref_clk(ref_clk), .arst_n(arst_n), .x_val(isq_s2_r),
		.rsns_milli_x100(rsns_milli_x100), .y_val(squared_current_reading));

	direct_encoder #(.XW(32), .YW(`W16), .X_DIV(10000), .M(`PWR_M), .B(`PWR_B),
		.EXP(telemetry_pkg::EXP_M2), .SCALE_RSNS(1'b1)) u_pin (
		.ref_clk(ref_clk), .arst_n(arst_n), .x_val(pin_x10000),
		.rsns_milli_x100(rsns_milli_x100), .y_val(pin_reading));

	direct_encoder #(.XW(32), .YW(`W24), .X_DIV(10000), .M(`PWRX_M), .B(`PWRX_B),
		.EXP(telemetry_pkg::EXP_0), .SCALE_RSNS(1'b1)) u_pinx (
		.ref_clk(ref_clk), .arst_n(arst_n), .x_val(pin_x10000),
		.rsns_milli_x100(rsns_milli_x100), .y_val(extended_power_reading));

	// Input is (degC+273)x10; b is lowered by m*273 so the code keeps its offset
	// while a sensor at absolute zero still codes without a negative term
	direct_encoder #(.XW(24), .YW(`W12), .X_DIV(10), .M(`TEMP_M), .B(TEMP_B_K),
		.EXP(telemetry_pkg::EXP_M1), .SCALE_RSNS(1'b0)) u_temp (
		.ref_clk(ref_clk), .arst_n(arst_n), .x_val(24'(temp_s2_r)),
		.rsns_milli_x100(rsns_milli_x100), .y_val(temp_reading));

	// Limit decode by the inverse, in degC+273: (10*Y - re-based b) / m
	// Codes below absolute zero read back as 0 rather than wrapping
	always_comb
	begin
		limit_x10 = 16'(ot_fault_limit_code) * 16'h000A;
		if (limit_x10 > TEMP_B_K)
			limit_nxt = 12'((limit_x10 - TEMP_B_K) / `TEMP_M);
		else
			limit_nxt = 12'h000;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ot_limit_degc_plus273 <= 12'h000;
			ot_fault <= 1'b0;
		end
		else
		begin
			ot_limit_degc_plus273 <= limit_nxt;
			ot_fault <= temp_reading >= ot_fault_limit_code;
		end
	end

	// Conversion tick every 102.4 us
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_r <= '0;
		else if (tick_r == CW'(CONV_CYCLES - 1))
			tick_r <= '0;
		else
			tick_r <= tick_r + 1'b1;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_r <= telemetry_pkg::ST_IDLE;
		else
			case (state_r)
				telemetry_pkg::ST_IDLE: state_r <= telemetry_pkg::ST_CONV;
				telemetry_pkg::ST_CONV:
					if (tick_r == CW'(CONV_CYCLES - 1))
						state_r <= telemetry_pkg::ST_ACC;
				telemetry_pkg::ST_ACC: state_r <= telemetry_pkg::ST_CONV;
				default: state_r <= telemetry_pkg::ST_IDLE;
			endcase
	end

	assign conv_done = (state_r == telemetry_pkg::ST_ACC);
	assign acc_sum = {rollover_count, energy_count} + (ACC_W+ROLL_W)'(pin_reading);

	// Rollover sits above the power sum; all three wrap naturally
	// One 24-bit counter, so a host delta across a single wrap stays exact
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			energy_count <= '0;
			rollover_count <= '0;
			sample_count <= '0;
		end
		else if (conv_done)
		begin
			{rollover_count, energy_count} <= acc_sum;
			sample_count <= sample_count + 1'b1;
		end
	end
endmodule // telemetry_direct_format_energy

// ===== telemetry_map.svh
// Constants of the telemetry direct-format encoder and energy accumulator.
// Assumes a 100 MHz ref_clk; included by bare name by the design files.
`ifndef TELEMETRY_MAP_SVH
`define TELEMETRY_MAP_SVH

// Voltage, 88 V telemetry range
`define VOLT_M 16'd4653
`define VOLT_B 16'd0
// Current, 12.5 mV sense setting, per 1 mOhm
`define CURR_M 16'd23165
`define CURR_B 16'd0
// Squared-current reading
`define ISQ_M 16'd20808
`define ISQ_B 16'd0
// Power 16-bit and 24-bit
`define PWR_M 16'd4211
`define PWR_B 16'd0
`define PWRX_M 16'd10780
`define PWRX_B 16'd0
// Temperature
`define TEMP_M 16'd52
`define TEMP_B 16'd14321
// Field widths
`define W12 12
`define W16 16
`define W24 24
// Conversion period in ns (102.4 us)
`define CONV_PERIOD_NS 102400
`define CLK_PERIOD_NS 10
`define CONV_CYCLES (`CONV_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ===== telemetry_pkg.sv
// Types shared by the telemetry encoder files.
// Assumes telemetry_map.svh holds all numeric constants.
package telemetry_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_ACC = 2'b11
	} conv_state_t;
	// Exponent choice: 10^0, 10^-1 or 10^-2
	typedef enum logic [1:0] {
		EXP_0 = 2'b00,
		EXP_M1 = 2'b01,
		EXP_M2 = 2'b10
	} exp_t;
endpackage

// ===== direct_encoder.sv
// One direct-format encoder: Y = trunc((m*X + b) * 10^R * rsns), saturated.
// Assumes X already holds the real value in units of 1/X_DIV (fixed point).
`timescale 1ns/1ps
`include "telemetry_map.svh"
module direct_encoder #(
	parameter int XW = 24,
	parameter int YW = 12,
	parameter int X_DIV = 100,
	parameter logic [15:0] M = 16'd1,
	parameter logic [15:0] B = 16'd0,
	parameter telemetry_pkg::exp_t EXP = telemetry_pkg::EXP_0,
	parameter bit SCALE_RSNS = 1'b0
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Operands
	input wire logic [XW-1:0] x_val,
	input wire logic [15:0] rsns_milli_x100,
	// Result
	output logic [YW-1:0] y_val
);
	localparam int PW = XW + 48;
	logic [PW-1:0] num;
	logic [PW-1:0] den;
	logic [PW-1:0] quo;

	always_comb
	begin
		num = PW'(x_val) * PW'(M) + PW'(X_DIV) * PW'(B);
		if (SCALE_RSNS)
			num = num * PW'(rsns_milli_x100);
		den = PW'(X_DIV);
		if (SCALE_RSNS)
			den = den * PW'(100);
		case (EXP)
			telemetry_pkg::EXP_M1: den = den * PW'(10);
			telemetry_pkg::EXP_M2: den = den * PW'(100);
			default: den = den;
		endcase
		quo = num / den;
	end

	// Truncate, then clamp to the field instead of wrapping
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			y_val <= '0;
		else if (quo > PW'({YW{1'b1}}))
			y_val <= {YW{1'b1}};
		else
			y_val <= quo[YW-1:0];
	end
endmodule // direct_encoder

// ===== tde_assertions.sv
// Port checker for the telemetry encoder.
// Bound from the bench; sees top-level ports only.
`timescale 1ns/1ps
module tde_assertions #(
	parameter int CONV_CYCLES = 8
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Inputs watched
	input wire logic voltage_telemetry_range,
	input wire logic [1:0] current_sense_threshold_setting,
	input wire logic [15:0] vin_x100,
	input wire logic [15:0] temp_c_x10_plus2730,
	input wire logic [11:0] ot_fault_limit_code,
	// Outputs watched
	input wire logic [11:0] vin_reading,
	input wire logic [15:0] pin_reading,
	input wire logic [11:0] temp_reading,
	input wire logic ot_fault,
	input wire logic coeff_valid,
	input wire logic [15:0] sample_count,
	input wire logic [7:0] rollover_count,
	input wire logic [15:0] energy_count,
	input wire logic conv_done
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic [31:0] gap_r, v_exp, t_exp;
	logic seen_r;
	// Temperature code reworked for inputs in tenths above -273
	assign v_exp = (32'(vin_x100) * 32'h122D) / 32'h2710;
	assign t_exp = (32'(temp_c_x10_plus2730) * 32'h34 + 32'h4E2) / 32'h64;
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			gap_r <= '0;
		else
			gap_r <= conv_done ? '0 : gap_r + 32'h1;
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			seen_r <= 1'b0;
		else
			seen_r <= seen_r | conv_done;
	sequence calm_v;
		$stable(vin_x100) [*5];
	endsequence
	sequence calm_t;
		($stable(temp_c_x10_plus2730) && $stable(ot_fault_limit_code)) [*5];
	endsequence
	AST_CONV_PERIOD: assert property (seen_r |-> gap_r < CONV_CYCLES
		&& (!conv_done || gap_r == CONV_CYCLES - 1)) else $error("conversion spacing wrong");
	AST_VIN_ENC: assert property (calm_v |-> vin_reading ==
		(v_exp > 32'hFFF ? 12'hFFF : v_exp[11:0])) else $error("voltage code wrong");
	AST_TEMP_ENC: assert property (calm_t ##0 temp_c_x10_plus2730 >= 16'h0AAA |->
		temp_reading == (t_exp > 32'hFFF ? 12'hFFF : t_exp[11:0])) else $error("temp code wrong");
	// Flag is registered, so it follows last cycle's reading and limit
	AST_OT_FAULT: assert property (calm_t |-> ot_fault ==
		($past(temp_reading) >= $past(ot_fault_limit_code))) else $error("fault flag wrong");
	AST_COEFF: assert property (($stable(voltage_telemetry_range)
		&& $stable(current_sense_threshold_setting)) [*5] |-> coeff_valid ==
		(voltage_telemetry_range && current_sense_threshold_setting == 2'h0))
		else $error("coefficient flag wrong");
	AST_SAMPLE_INC: assert property (conv_done |=>
		sample_count == $past(sample_count) + 16'h1) else $error("sample count wrong");
	AST_ENERGY_ADD: assert property (conv_done |=>
		{rollover_count, energy_count} == $past({rollover_count, energy_count})
		+ 24'($past(pin_reading))) else $error("energy sum wrong");
	AST_ENERGY_HOLD: assert property (!conv_done |=> $stable(sample_count)
		&& $stable({rollover_count, energy_count})) else $error("energy moved");
endmodule // tde_assertions

// ===== tde_host_model.sv
// Host model: snapshots the energy readout, averages power.
// Assumes mark is a one-cycle strobe from the bench.
`timescale 1ns/1ps
module tde_host_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Snapshot strobe and readout
	input wire logic mark,
	input wire logic [15:0] sample_count,
	input wire logic [7:0] rollover_count,
	input wire logic [15:0] energy_count,
	// Averaged power code and sample delta
	output logic [15:0] avg_pin,
	output logic [15:0] dcount
);
	logic [23:0] acc0_r, dacc;
	logic [15:0] cnt0_r;
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			{acc0_r, cnt0_r} <= '0;
		else if (mark)
			{acc0_r, cnt0_r} <= {rollover_count, energy_count, sample_count};
	// Wraps of the concatenated sum cancel in the difference
	assign dacc = {rollover_count, energy_count} - acc0_r;
	assign dcount = sample_count - cnt0_r;
	assign avg_pin = dcount == 16'h0 ? 16'h0 : 16'(dacc / 24'(dcount));
endmodule // tde_host_model

// ===== telemetry_direct_format_energy_tb.sv
// Bench for the telemetry encoder and energy accumulator.
// Drives plain ports; host model averages the energy readout.
`timescale 1ns/1ps
module telemetry_direct_format_energy_tb;
	logic ref_clk, arst_n, voltage_telemetry_range, ot_fault, coeff_valid, conv_done, mark;
	logic [1:0] current_sense_threshold_setting;
	logic [15:0] rsns_milli_x100, vin_x100, iout_x100, temp_c_x10_plus2730, pin_reading;
	logic [15:0] squared_current_reading, sample_count, energy_count, avg_pin, dcount;
	logic [23:0] isq_x100, extended_power_reading;
	logic [11:0] ot_fault_limit_code, vin_reading, iout_reading, temp_reading;
	logic [11:0] ot_limit_degc_plus273;
	logic [7:0] rollover_count;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	telemetry_direct_format_energy #(.CONV_CYCLES(8)) i_dut (.ref_clk, .arst_n,
		.voltage_telemetry_range, .current_sense_threshold_setting, .rsns_milli_x100,
		.vin_x100, .iout_x100, .isq_x100, .temp_c_x10_plus2730, .ot_fault_limit_code,
		.vin_reading, .iout_reading, .squared_current_reading, .pin_reading,
		.extended_power_reading, .temp_reading, .ot_fault, .ot_limit_degc_plus273,
		.coeff_valid, .sample_count, .rollover_count, .energy_count, .conv_done);
	tde_host_model i_host (.ref_clk, .arst_n, .mark, .sample_count, .rollover_count,
		.energy_count, .avg_pin, .dcount);
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wcd;
		int n;
		n = 0;
		do
		begin
			wt(1);
			n++;
		end
		while (conv_done !== 1'b1 && n < 20);
		chk(24'(n <= 8), 24'h1);
	endtask
	task automatic results;
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			results;
		end
	end
	initial
	begin
		{arst_n, mark, current_sense_threshold_setting} = '0;
		voltage_telemetry_range = 1'b1;
		rsns_milli_x100 = 16'h0032;
		vin_x100 = 16'h0FA0;
		iout_x100 = 16'h03E8;
		isq_x100 = 24'h001388;
		temp_c_x10_plus2730 = 16'h1086;
		ot_fault_limit_code = 12'h8A4;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		wt(6);
		chk(24'(vin_reading), 24'h745);
		chk(24'(iout_reading), 24'h486);
		chk(24'(squared_current_reading), 24'h1452);
		chk(24'(pin_reading), 24'h20E6);
		chk(extended_power_reading, 24'h20E5E0);
		chk(24'(temp_reading), 24'h8A4);
		chk(24'(ot_fault), 24'h1);
		chk(24'(ot_limit_degc_plus273), 24'h1A6);
		chk(24'(coeff_valid), 24'h1);
		@(posedge ref_clk) ot_fault_limit_code <= 12'hFFF;
		wt(6);
		chk(24'(ot_fault), 24'h0);
		chk(24'(ot_limit_degc_plus273), 24'h311);
		@(posedge ref_clk) ot_fault_limit_code <= 12'h000;
		wt(6);
		chk(24'(ot_fault), 24'h1);
		chk(24'(ot_limit_degc_plus273), 24'h000);
		@(posedge ref_clk) vin_x100 <= 16'hFFFF;
		wt(6);
		chk(24'(vin_reading), 24'hFFF);
		chk(24'(pin_reading), 24'hFFFF);
		chk(extended_power_reading, 24'hFFFFFF);
		@(posedge ref_clk) {vin_x100, current_sense_threshold_setting} <= {16'h0FA0, 2'h1};
		wt(6);
		chk(24'(coeff_valid), 24'h0);
		@(posedge ref_clk) current_sense_threshold_setting <= 2'h0;
		wt(6);
		wcd;
		@(posedge ref_clk) mark <= 1'b1;
		@(posedge ref_clk) mark <= 1'b0;
		repeat (10) wcd;
		wt(2);
		chk(24'(dcount), 24'hA);
		chk(24'(avg_pin), 24'h20E6);
		// Mid-run reset clears the readout; first sample lands one period later
		@(posedge ref_clk) arst_n <= 1'b0;
		wt(1);
		chk(24'(sample_count), 24'h0);
		chk({rollover_count, energy_count}, 24'h000000);
		chk(24'(conv_done), 24'h0);
		@(posedge ref_clk) arst_n <= 1'b1;
		wt(6);
		chk(24'(vin_reading), 24'h745);
		wcd;
		wt(1);
		chk(24'(sample_count), 24'h1);
		chk({rollover_count, energy_count}, 24'h0020E6);
		results;
	end
endmodule // telemetry_direct_format_energy_tb
bind telemetry_direct_format_energy tde_assertions #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
	.ref_clk, .arst_n, .voltage_telemetry_range, .current_sense_threshold_setting,
	.vin_x100, .temp_c_x10_plus2730, .ot_fault_limit_code, .vin_reading, .pin_reading,
	.temp_reading, .ot_fault, .coeff_valid, .sample_count, .rollover_count,
	.energy_count, .conv_done);
